/* shared/lpa_params.svh */
// Register offsets, field positions and reset values of the partner ability block
`ifndef LPA_PARAMS_SVH
`define LPA_PARAMS_SVH

// Register indices; byte address is four times the index
`define LPA_IDX_PARTNER_ABILITY 6'h05
`define LPA_IDX_CONTROL 6'h10
`define LPA_IDX_STATUS 6'h11
`define LPA_IDX_LSB 2
`define LPA_IDX_MSB 7

// Partner ability word fields, both views
`define LPA_BIT_NEXT_PAGE 15
`define LPA_BIT_ACK 14
`define LPA_BIT_REMOTE_FAULT 13
`define LPA_BIT_RESERVED 12
`define LPA_BIT_ASYM_PAUSE 11
`define LPA_BIT_PAUSE 10
`define LPA_BIT_FOUR_PAIR 9
`define LPA_BIT_FAST_FULL 8
`define LPA_BIT_FAST_HALF 7
`define LPA_BIT_TEN_FULL 6
`define LPA_BIT_TEN_HALF 5
`define LPA_SELECTOR_MSB 4
`define LPA_BIT_MESSAGE_PAGE 13
`define LPA_BIT_CAN_COMPLY 12
`define LPA_BIT_TOGGLE 11
`define LPA_CODE_MSB 10

// Control register fields
`define LPA_CTRL_NP_SUPPORT 0
`define LPA_CTRL_FORCE_BASE 1
`define LPA_CTRL_WIDTH 2

// Status register fields
`define LPA_STAT_BASE_RX 0
`define LPA_STAT_NEXT_RX 1
`define LPA_STAT_VIEW_NEXT 2
`define LPA_STAT_AN_DONE 3
`define LPA_STAT_COUNT_LSB 8
`define LPA_STAT_COUNT_MSB 15

// Reset values
`define LPA_WORD_RESET 16'h0000
`define LPA_CTRL_RESET 2'h0
`define LPA_COUNT_RESET 8'h00
`define LPA_DATA_RESET 32'h0000_0000

// Bus responses
`define LPA_RESP_OKAY 2'h0
`define LPA_RESP_DECERR 2'h3

`endif

/* shared/lpa_pkg.sv */
// Types shared by the partner ability register block
`default_nettype none
package lpa_pkg;

    // Base page as received from the partner
    typedef struct packed {
        logic next_page_request;
        logic ack;
        logic remote_fault_flag;
        logic reserved;
        logic asymmetric_pause_ability;
        logic pause_ability;
        logic four_pair_ability;
        logic fast_full_duplex_ability;
        logic fast_half_duplex_ability;
        logic ten_full_duplex_ability;
        logic ten_half_duplex_ability;
        logic [4:0] selector;
    } lpa_base_page_t;

    // Next page as received from the partner
    typedef struct packed {
        logic next_page_request;
        logic ack;
        logic message_page_flag;
        logic partner_can_comply;
        logic toggle;
        logic [10:0] code;
    } lpa_next_page_t;

    // Strobe and word from the negotiation engine
    typedef struct packed {
        logic valid;
        lpa_base_page_t word;
    } lpa_base_rx_t;

    typedef struct packed {
        logic valid;
        lpa_next_page_t word;
    } lpa_next_rx_t;

    typedef enum logic {
        LPA_VIEW_BASE = 1'b0,
        LPA_VIEW_NEXT = 1'b1
    } lpa_view_t;

endpackage
`default_nettype wire

/* hdl/lpa_page_store.sv */
// Holds the received base and next pages and presents the selected view
`default_nettype none
`include "lpa_params.svh"
module lpa_page_store
    import lpa_pkg::*;
#(
    parameter int WORD_WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic base_load,
    input wire logic [WORD_WIDTH-1:0] base_word,
    input wire logic next_load,
    input wire logic [WORD_WIDTH-1:0] next_word,
    input wire logic show_next,
    output logic [WORD_WIDTH-1:0] view_word
);

    logic [WORD_WIDTH-1:0] base_q;
    logic [WORD_WIDTH-1:0] next_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_q <= `LPA_WORD_RESET;
        end else if (base_load) begin
            base_q <= base_word;
            // Reserved position always reads back as zero
            base_q[`LPA_BIT_RESERVED] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_q <= `LPA_WORD_RESET;
        end else if (next_load) begin
            next_q <= next_word;
        end
    end

    // Registered read port, one cycle behind a view change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            view_word <= `LPA_WORD_RESET;
        end else begin
            view_word <= show_next ? next_q : base_q;
        end
    end

endmodule
`default_nettype wire

/* hdl/lpa_regs.sv */
// Partner ability register bank with an AXI4-Lite slave port
// Notes on behaviour
// - Load partner ability word from negotiation; software sees it read-only.
// - With next pages supported, show received next page after negotiation completes.
// - Base view bit 15: partner requests next-page exchange; resets to 0.
// - Base view bit 14: partner acknowledged our word, set by negotiation.
// - Base view bit 13: partner signalled remote fault; resets to 0.
// - Base view bit 12 reserved: always reads 0; software writes it as 0.
// - Base view bit 11: partner supports asymmetric pause; resets to 0.
// - Base view bit 10: partner supports symmetric pause; resets to 0.
// - Base view bit 9: partner supports four-pair 100 Mb/s; resets to 0.
// - Base view bit 8: partner supports 100 Mb/s full duplex.
// - Base view bit 7: partner supports 100 Mb/s half duplex.
// - Base view bit 6: partner supports 10 Mb/s full duplex.
// - Base view bit 5: partner supports 10 Mb/s half duplex.
// - Bits 4..0 hold partner's protocol selector as received; reset zero.
// - Next-page view at same address; bit 15 requests further next pages.
// - Next-page view: bit 13 message page flag, bits 10..0 code field.
// - Next-page view: bit 12 can comply, bit 11 received toggle.
//
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none
`include "lpa_params.svh"
module lpa_regs
    import lpa_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,
    parameter int WORD_WIDTH = 16,
    parameter int COUNT_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lpa_base_rx_t base_rx,
    input wire lpa_next_rx_t next_rx,
    input wire logic an_complete,
    input wire logic an_restart,
    output logic [WORD_WIDTH-1:0] partner_ability_word,
    output logic partner_view_next
);

    // Register index from a byte address
    function automatic logic [5:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
        reg_index = addr[`LPA_IDX_MSB:`LPA_IDX_LSB];
    endfunction

    // Whether an index names a mapped register
    function automatic logic reg_mapped(input logic [5:0] idx);
        reg_mapped = (idx == `LPA_IDX_PARTNER_ABILITY) || (idx == `LPA_IDX_CONTROL) ||
                     (idx == `LPA_IDX_STATUS);
    endfunction

    logic [ADDR_WIDTH-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [`LPA_CTRL_WIDTH-1:0] control;
    logic base_seen;
    logic next_seen;
    logic an_done;
    logic [COUNT_WIDTH-1:0] next_count;
    lpa_view_t view;
    lpa_view_t next_view;
    logic [WORD_WIDTH-1:0] view_word;
    logic write_fire;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic clear_base;
    logic clear_next;
    logic show_next;
    logic [31:0] status_word;

    assign write_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr);
    assign rd_idx = reg_index(s_axi_araddr);
    assign clear_base = write_fire && (wr_idx == `LPA_IDX_STATUS) && w_strb[0] &&
                        w_data[`LPA_STAT_BASE_RX];
    assign clear_next = write_fire && (wr_idx == `LPA_IDX_STATUS) && w_strb[0] &&
                        w_data[`LPA_STAT_NEXT_RX];
    // Software can still look back at the base page after next pages arrive
    assign show_next = (view == LPA_VIEW_NEXT) && !control[`LPA_CTRL_FORCE_BASE];

    always_comb begin
        status_word = `LPA_DATA_RESET;
        status_word[`LPA_STAT_BASE_RX] = base_seen;
        status_word[`LPA_STAT_NEXT_RX] = next_seen;
        status_word[`LPA_STAT_VIEW_NEXT] = show_next;
        status_word[`LPA_STAT_AN_DONE] = an_done;
        status_word[`LPA_STAT_COUNT_MSB:`LPA_STAT_COUNT_LSB] = next_count;
    end

    // The page words themselves live in the store
    lpa_page_store #(
        .WORD_WIDTH(WORD_WIDTH)
    ) u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .base_load(base_rx.valid),
        .base_word(base_rx.word),
        .next_load(next_rx.valid),
        .next_word(next_rx.word),
        .show_next(show_next),
        .view_word(view_word)
    );

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= `LPA_DATA_RESET;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Write response; the ability word accepts the write but keeps its value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPA_RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_mapped(wr_idx) ? `LPA_RESP_OKAY : `LPA_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= `LPA_CTRL_RESET;
        end else if (write_fire && (wr_idx == `LPA_IDX_CONTROL) && w_strb[0]) begin
            control <= w_data[`LPA_CTRL_WIDTH-1:0];
        end
    end

    // Sticky receive flags; a new page wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_seen <= 1'b0;
        end else if (base_rx.valid) begin
            base_seen <= 1'b1;
        end else if (clear_base) begin
            base_seen <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_seen <= 1'b0;
        end else if (next_rx.valid) begin
            next_seen <= 1'b1;
        end else if (clear_next) begin
            next_seen <= 1'b0;
        end
    end

    // Next page count, saturating, restarted with each negotiation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_count <= `LPA_COUNT_RESET;
        end else if (an_restart) begin
            next_count <= `LPA_COUNT_RESET;
        end else if (next_rx.valid && !(&next_count)) begin
            next_count <= next_count + COUNT_WIDTH'(1);
        end
    end

    // Completion seen for the current negotiation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            an_done <= 1'b0;
        end else if (an_restart) begin
            an_done <= 1'b0;
        end else if (an_complete) begin
            an_done <= 1'b1;
        end
    end

    // View selection
    always_comb begin
        next_view = view;
        unique case (view)
            LPA_VIEW_BASE: begin
                if (!an_restart && an_complete && control[`LPA_CTRL_NP_SUPPORT] &&
                    (next_seen || next_rx.valid)) begin
                    next_view = LPA_VIEW_NEXT;
                end
            end
            LPA_VIEW_NEXT: begin
                if (an_restart || !control[`LPA_CTRL_NP_SUPPORT]) begin
                    next_view = LPA_VIEW_BASE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            view <= LPA_VIEW_BASE;
        end else begin
            view <= next_view;
        end
    end

    // Read channel, one request at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `LPA_DATA_RESET;
            s_axi_rresp <= `LPA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= reg_mapped(rd_idx) ? `LPA_RESP_OKAY : `LPA_RESP_DECERR;
            if (rd_idx == `LPA_IDX_PARTNER_ABILITY) begin
                s_axi_rdata <= {{(32 - WORD_WIDTH){1'b0}}, view_word};
            end else if (rd_idx == `LPA_IDX_CONTROL) begin
                s_axi_rdata <= {{(32 - `LPA_CTRL_WIDTH){1'b0}}, control};
            end else if (rd_idx == `LPA_IDX_STATUS) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= `LPA_DATA_RESET;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Registered copies for the rest of the transceiver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            partner_ability_word <= `LPA_WORD_RESET;
            partner_view_next <= 1'b0;
        end else begin
            partner_ability_word <= view_word;
            partner_view_next <= show_next;
        end
    end

endmodule
`default_nettype wire

/* verification/lpa_regs_asserts.sv */
// Checker for the partner ability register bank
`default_nettype none
module lpa_regs_asserts
    import lpa_pkg::*;
#(
    parameter int WORD_WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire lpa_base_rx_t base_rx,
    input wire lpa_next_rx_t next_rx,
    input wire logic an_complete,
    input wire logic an_restart,
    input wire logic [WORD_WIDTH-1:0] partner_ability_word,
    input wire logic partner_view_next
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_clear_a: assert property ($rose(aresetn) |-> partner_ability_word == '0
        && !partner_view_next) else $error("ability word not clear after reset");
    base_view_a: assert property (base_rx.valid && !an_complete ##1 !base_rx.valid
        && !an_complete && !partner_view_next ##1 !partner_view_next
        |=> partner_ability_word == ($past(base_rx.word, 3) & 16'hefff))
        else $error("base page not shown");
    next_view_a: assert property (next_rx.valid && partner_view_next ##1 !next_rx.valid
        && partner_view_next ##1 partner_view_next
        |=> partner_ability_word == $past(next_rx.word, 3)) else $error("next page not shown");
    restart_base_a: assert property (an_restart |-> ##[1:2] !partner_view_next)
        else $error("view not back to base");
    view_hold_a: assert property ((!an_complete) [*3] ##0 !partner_view_next
        |=> !partner_view_next) else $error("view left base early");
    word_hold_a: assert property ((!base_rx.valid && !next_rx.valid && !an_complete
        && !partner_view_next) [*3] |=> $stable(partner_ability_word))
        else $error("ability word changed without a page");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held");
    cover property (base_rx.valid);
    cover property (next_rx.valid && partner_view_next);
    cover property (an_restart && partner_view_next);
endmodule
bind lpa_regs lpa_regs_asserts #(.WORD_WIDTH(WORD_WIDTH)) u_asserts (.aclk(aclk),
    .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .base_rx(base_rx), .next_rx(next_rx),
    .an_complete(an_complete), .an_restart(an_restart),
    .partner_ability_word(partner_ability_word), .partner_view_next(partner_view_next));
`default_nettype wire

/* verification/lpa_partner_model.sv */
// Negotiation engine stand-in delivering pages received from the partner
`default_nettype none
module lpa_partner_model
    import lpa_pkg::*;
(
    input wire logic aclk,
    output lpa_base_rx_t base_rx,
    output lpa_next_rx_t next_rx,
    output logic an_complete,
    output logic an_restart
);
    timeunit 1ns;
    timeprecision 1ns;
    logic toggle_q;
    initial begin
        base_rx = '0;
        next_rx = '0;
        an_complete = 1'h0;
        an_restart = 1'h0;
        toggle_q = 1'h0;
    end
    // Word lines go inverse once the strobe drops, so stale data cannot pass
    task automatic send_base(input lpa_base_page_t w);
        @(posedge aclk);
        base_rx <= {1'h1, w};
        @(posedge aclk);
        base_rx <= {1'h0, ~w};
    endtask
    task automatic send_next(input lpa_next_page_t w, output lpa_next_page_t sent);
        sent = w;
        sent.toggle = toggle_q;
        toggle_q = ~toggle_q;
        @(posedge aclk);
        next_rx <= {1'h1, sent};
        @(posedge aclk);
        next_rx <= {1'h0, ~sent};
    endtask
    task automatic set_complete(input logic c);
        @(posedge aclk);
        an_complete <= c;
    endtask
    task automatic restart();
        @(posedge aclk);
        an_restart <= 1'h1;
        @(posedge aclk);
        an_restart <= 1'h0;
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Testbench for the partner ability register bank
`default_nettype none
module tb_top
    import lpa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] word;
        logic [31:0] exp;
    } lpa_row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, an_complete, an_restart, view_next;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] ability;
    lpa_base_rx_t base_rx;
    lpa_next_rx_t next_rx;
    lpa_next_page_t sent;
    int failures = 0;
    int n_compared = 0;
    lpa_row_t rows [13] = '{
        '{16'h8000, 32'h8000},
        '{16'h4000, 32'h4000},
        '{16'h2000, 32'h2000},
        '{16'h1000, 32'h0000},
        '{16'h0800, 32'h0800},
        '{16'h0400, 32'h0400},
        '{16'h0200, 32'h0200},
        '{16'h0100, 32'h0100},
        '{16'h0080, 32'h0080},
        '{16'h0040, 32'h0040},
        '{16'h0020, 32'h0020},
        '{16'hffff, 32'hefff},
        '{16'h001f, 32'h001f}
    };
    always #50 aclk = ~aclk;
    lpa_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .base_rx(base_rx), .next_rx(next_rx), .an_complete(an_complete),
        .an_restart(an_restart), .partner_ability_word(ability),
        .partner_view_next(view_next));
    lpa_partner_model u_partner (.aclk(aclk), .base_rx(base_rx), .next_rx(next_rx),
        .an_complete(an_complete), .an_restart(an_restart));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic read_check(input string name, input logic [7:0] a,
        input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                check(name, exp, rdata);
                check({name, " resp"}, {30'h0, er}, {30'h0, rresp});
                rready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles; the margin is generous
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        read_check("reset word", 8'h14, 32'h0, 2'h0);
        check("reset view", 32'h0, {31'h0, view_next});
        $display("test reset done");
        foreach (rows[i]) begin
            u_partner.send_base(rows[i].word);
            read_check("base word", 8'h14, rows[i].exp, 2'h0);
            check("port word", rows[i].exp, {16'h0, ability});
        end
        $display("test base fields done");
        axi_write(8'h14, 32'h0000_ffff);
        check("ro write resp", 32'h0, {30'h0, resp});
        read_check("after ro write", 8'h14, 32'h001f, 2'h0);
        axi_write(8'h3c, 32'h0000_0001);
        check("unmapped write resp", 32'h3, {30'h0, resp});
        read_check("unmapped read", 8'h3c, 32'h0, 2'h3);
        $display("test access kinds done");
        // Without next-page support the base view must survive completion
        u_partner.set_complete(1'h1);
        u_partner.send_next(16'h2005, sent);
        repeat (3) @(posedge aclk);
        check("view unsupported", 32'h0, {31'h0, view_next});
        read_check("base kept", 8'h14, 32'h001f, 2'h0);
        axi_write(8'h40, 32'h0000_0001);
        u_partner.send_next(16'h3401, sent);
        repeat (3) @(posedge aclk);
        check("view next", 32'h1, {31'h0, view_next});
        read_check("next page", 8'h14, {16'h0, sent}, 2'h0);
        u_partner.send_next(16'h8155, sent);
        read_check("second page", 8'h14, {16'h0, sent}, 2'h0);
        // Three next pages so far, completion seen, next view shown
        read_check("status next", 8'h44, 32'h0000_030f, 2'h0);
        axi_write(8'h40, 32'h0000_0003);
        read_check("forced base", 8'h14, 32'h001f, 2'h0);
        check("view forced", 32'h0, {31'h0, view_next});
        axi_write(8'h40, 32'h0000_0001);
        read_check("control", 8'h40, 32'h0000_0001, 2'h0);
        $display("test next pages done");
        u_partner.set_complete(1'h0);
        u_partner.restart();
        repeat (3) @(posedge aclk);
        check("view after restart", 32'h0, {31'h0, view_next});
        read_check("base after restart", 8'h14, 32'h001f, 2'h0);
        // Restart clears count and completion but not the sticky page flags
        read_check("status restart", 8'h44, 32'h0000_0003, 2'h0);
        axi_write(8'h44, 32'h0000_0003);
        read_check("status cleared", 8'h44, 32'h0000_0000, 2'h0);
        $display("test restart done");
        stop_test();
    end
endmodule
`default_nettype wire
